// ---- inc/data_space_pkg.sv ----
// Behaviour
// - Data addresses 0x00-0x1F hit the working registers
// - Next 64 addresses go to standard I/O
// - Next 160 are extended I/O, data ops only
// - Next 4096 are SRAM; 4352 locations decoded
// - Every SRAM access completes in two cycles
// - Short I/O form: 0x00-0x3F, data address plus 0x20
// - Bit operations only on I/O 0x00-0x1F
// - Bit set/clear writes only the addressed bit
// - Some status flags clear on writing one
// - Displacement: second/third pointer plus 0..63
// - Pre-decrement and post-increment write pointer back
// - Direct addressing reaches the whole decoded space
// - Top six working registers form three pointers
// - Byte-store read trigger stalls core four cycles
// - Byte-store write trigger stalls core two cycles
// - Three general-purpose I/O registers, low one bit-addressable
// - Register region is the register file itself
// - Each pointer is 16 bits from a register pair
package data_space_pkg;

	localparam logic [15:0] REGFILE_BASE    = 16'h0000;
	localparam logic [15:0] IO_BASE         = 16'h0020;
	localparam logic [15:0] EXT_IO_BASE     = 16'h0060;
	localparam logic [15:0] SRAM_BASE       = 16'h0100;
	localparam int          SRAM_DEPTH      = 4096;
	localparam logic [15:0] IO_DATA_OFFSET  = 16'h0020;
	localparam logic [5:0]  BIT_IO_LIMIT    = 6'h20;
	localparam logic [4:0]  PTR_BASE_IDX    = 5'h1A;
	localparam logic [7:0]  GP0_DATA_ADDR   = 8'h3E;
	localparam logic [7:0]  GP1_DATA_ADDR   = 8'h4A;
	localparam logic [7:0]  GP2_DATA_ADDR   = 8'h4B;
	localparam logic [7:0]  FLAG_DATA_ADDR  = 8'h35;
	localparam logic [7:0]  STORE_CTRL_ADDR = 8'h3F;
	localparam int          STORE_READ_BIT  = 0;
	localparam int          STORE_WRITE_BIT = 1;
	localparam logic [2:0]  STORE_READ_STALL  = 3'h4;
	localparam logic [2:0]  STORE_WRITE_STALL = 3'h2;
	localparam logic [7:0]  UNMAPPED_READ   = 8'h00;

	typedef enum logic [3:0] {
		no_op, data_space_load_ops, data_space_store_ops, io_in_op, io_out_op,
		set_io_bit_op, clear_io_bit_op, skip_if_io_bit_set_op, skip_if_io_bit_clear_op
	} op_e;

	typedef enum logic [2:0] {mode_direct, mode_indirect, mode_disp, mode_predec, mode_postinc} mode_e;

	typedef enum logic [2:0] {reg_file_rgn, std_io_rgn, ext_io_rgn, sram_rgn, none_rgn} rgn_e;

	typedef struct packed {
		logic       valid;
		op_e        op;
		mode_e      mode;
		logic [1:0] ptr;
		logic [4:0] rd;
		logic [15:0] addr;
		logic [5:0] disp;
		logic [5:0] io_addr;
		logic [2:0] bit_idx;
	} req_s;

	typedef struct packed {
		logic       ready;
		logic       done;
		logic [7:0] rdata;
		logic       skip;
		logic       stall;
	} rsp_s;

	typedef struct packed {
		logic       sel;
		logic       we;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic [7:0] wmask;
	} io_bus_s;

	typedef struct packed {
		logic       we;
		logic [4:0] idx;
		logic [7:0] data;
	} rf_wr_s;

	function automatic rgn_e region_of(input logic [15:0] a, input logic [15:0] sram_end);
		if (a < IO_BASE)
			return reg_file_rgn;
		else if (a < EXT_IO_BASE)
			return std_io_rgn;
		else if (a < SRAM_BASE)
			return ext_io_rgn;
		else if (a < sram_end)
			return sram_rgn;
		else
			return none_rgn;
	endfunction

	function automatic logic is_internal_io(input logic [15:0] a);
		return (a[15:8] == 8'h00) && (a[7:0] == GP0_DATA_ADDR || a[7:0] == GP1_DATA_ADDR ||
			a[7:0] == GP2_DATA_ADDR || a[7:0] == FLAG_DATA_ADDR);
	endfunction

	function automatic logic is_bit_op(input op_e op);
		return op == set_io_bit_op || op == clear_io_bit_op ||
			op == skip_if_io_bit_set_op || op == skip_if_io_bit_clear_op;
	endfunction

	function automatic logic is_write_op(input op_e op);
		return op == data_space_store_ops || op == io_out_op || op == set_io_bit_op || op == clear_io_bit_op;
	endfunction

endpackage

// ---- src/data_addr_former.sv ----
`timescale 1ns/1ps
module data_addr_former import data_space_pkg::*; (
	input  req_s              req,
	input  logic [2:0][15:0]  ptrs,
	output logic [15:0]       addr,
	output logic [15:0]       ptr_nxt,
	output logic              ptr_wb,
	output logic [1:0]        ptr_sel
);
	logic [15:0] base;

	always_comb begin
		ptr_sel = req.ptr;
		// Only the second and third pointers carry a displacement
		if (req.mode == mode_disp && req.ptr == 2'h0) begin
			ptr_sel = 2'h1;
		end
		base    = ptrs[ptr_sel];
		addr    = req.addr;
		ptr_nxt = base;
		ptr_wb  = 1'b0;
		case (req.mode)
			mode_direct: begin
				addr = req.addr;
			end
			mode_indirect: begin
				addr = base;
			end
			mode_disp: begin
				addr = base + {10'h000, req.disp};
			end
			mode_predec: begin
				addr    = base - 16'h0001;
				ptr_nxt = base - 16'h0001;
				ptr_wb  = 1'b1;
			end
			mode_postinc: begin
				addr    = base;
				ptr_nxt = base + 16'h0001;
				ptr_wb  = 1'b1;
			end
			default: begin
				addr = req.addr;
			end
		endcase
		// Short I/O form: I/O address plus the data-space offset
		if (req.op == io_in_op || req.op == io_out_op || is_bit_op(req.op)) begin
			addr   = {10'h000, req.io_addr} + IO_DATA_OFFSET;
			ptr_wb = 1'b0;
		end
	end
endmodule

// ---- src/data_space_decoder.sv ----
`timescale 1ns/1ps
module data_space_decoder import data_space_pkg::*; #(
	parameter int DEPTH = SRAM_DEPTH
) (
	input  logic         CLK_SYS,
	input  logic         RESET,
	input  req_s         REQ,
	input  rf_wr_s       REG_WR,
	input  logic [7:0]   IO_RDATA,
	input  logic [7:0]   FLAG_SET,
	output rsp_s         RSP,
	output io_bus_s      IO,
	output logic [7:0]   FLAGS
);
	localparam int          SIDX_W   = $clog2(DEPTH);
	localparam logic [15:0] SRAM_END = SRAM_BASE + 16'(DEPTH);

	typedef enum logic [1:0] {ST_IDLE, ST_ACCESS, ST_STALL} state_e;

	typedef struct packed {
		state_e                 st;
		op_e                    op;
		rgn_e                   rgn;
		logic [15:0]            addr;
		logic [4:0]             rd;
		logic [2:0]             bit_idx;
		logic [7:0]             wdata;
		logic [7:0]             wmask;
		logic                   ptr_wb;
		logic [1:0]             ptr_sel;
		logic [15:0]            ptr_nxt;
		logic [2:0]             stall_cnt;
		rsp_s                   rsp;
		io_bus_s                io;
		logic [31:0][7:0]       rf;
		logic [DEPTH-1:0][7:0]  sram;
		logic [2:0][7:0]        gp;
		logic [7:0]             flags;
	} state_s;

	state_s            s_r;
	state_s            s_nxt;
	logic [2:0][15:0]  ptrs;
	logic [15:0]       fa_addr;
	logic [15:0]       fa_ptr_nxt;
	logic              fa_ptr_wb;
	logic [1:0]        fa_ptr_sel;
	logic              take;

	// Pointers live in the top six working registers, low byte first
	always_comb begin
		for (int p = 0; p < 3; p++) begin
			ptrs[p] = {s_r.rf[PTR_BASE_IDX + 5'(2 * p + 1)], s_r.rf[PTR_BASE_IDX + 5'(2 * p)]};
		end
	end

	data_addr_former u_former (
		.req     (REQ),
		.ptrs    (ptrs),
		.addr    (fa_addr),
		.ptr_nxt (fa_ptr_nxt),
		.ptr_wb  (fa_ptr_wb),
		.ptr_sel (fa_ptr_sel)
	);

	// Ready gates the take too, so nothing slips in on the edge that ends reset
	assign take = (s_r.st == ST_IDLE) && s_r.rsp.ready && REQ.valid && (REQ.op != no_op);

	always_comb begin
		logic [7:0]        rd_val;
		logic [7:0]        merged;
		logic [7:0]        flag_clr;
		logic [7:0]        trig;
		logic [7:0]        bmask;
		logic              ext;
		logic [SIDX_W-1:0] sidx;
		rd_val   = UNMAPPED_READ;
		merged   = 8'h00;
		flag_clr = 8'h00;
		trig     = 8'h00;
		bmask    = 8'h01 << REQ.bit_idx;
		ext      = 1'b0;
		sidx     = SIDX_W'(s_r.addr - SRAM_BASE);
		s_nxt    = s_r;
		s_nxt.rsp.done = 1'b0;
		s_nxt.io.sel   = 1'b0;
		s_nxt.io.we    = 1'b0;
		if (REG_WR.we) begin
			s_nxt.rf[REG_WR.idx] = REG_WR.data;
		end
		case (s_r.st)
			ST_IDLE: begin
				if (take) begin
					s_nxt.st      = ST_ACCESS;
					s_nxt.op      = REQ.op;
					s_nxt.addr    = fa_addr;
					s_nxt.rgn     = region_of(fa_addr, SRAM_END);
					s_nxt.rd      = REQ.rd;
					s_nxt.bit_idx = REQ.bit_idx;
					s_nxt.ptr_wb  = fa_ptr_wb;
					s_nxt.ptr_sel = fa_ptr_sel;
					s_nxt.ptr_nxt = fa_ptr_nxt;
					s_nxt.rsp.skip = 1'b0;
					if (is_bit_op(REQ.op)) begin
						s_nxt.wmask = bmask;
						s_nxt.wdata = (REQ.op == set_io_bit_op) ? bmask : 8'h00;
						if (REQ.io_addr >= BIT_IO_LIMIT) begin
							s_nxt.rgn = none_rgn;
						end
					end else begin
						s_nxt.wmask = 8'hFF;
						s_nxt.wdata = s_r.rf[REQ.rd];
					end
					ext = (s_nxt.rgn == std_io_rgn || s_nxt.rgn == ext_io_rgn) && !is_internal_io(fa_addr);
					s_nxt.io.sel   = ext;
					s_nxt.io.we    = ext && is_write_op(REQ.op);
					s_nxt.io.addr  = fa_addr[7:0] - IO_DATA_OFFSET[7:0];
					s_nxt.io.wdata = s_nxt.wdata;
					s_nxt.io.wmask = s_nxt.wmask;
				end
			end
			ST_ACCESS: begin
				// Peripheral read data is taken while the select is up
				case (s_r.rgn)
					reg_file_rgn: rd_val = s_r.rf[s_r.addr[4:0]];
					std_io_rgn, ext_io_rgn: begin
						if (s_r.addr[7:0] == GP0_DATA_ADDR && s_r.addr[15:8] == 8'h00)
							rd_val = s_r.gp[0];
						else if (s_r.addr[7:0] == GP1_DATA_ADDR && s_r.addr[15:8] == 8'h00)
							rd_val = s_r.gp[1];
						else if (s_r.addr[7:0] == GP2_DATA_ADDR && s_r.addr[15:8] == 8'h00)
							rd_val = s_r.gp[2];
						else if (s_r.addr[7:0] == FLAG_DATA_ADDR && s_r.addr[15:8] == 8'h00)
							rd_val = s_r.flags;
						else
							rd_val = IO_RDATA;
					end
					sram_rgn: rd_val = s_r.sram[sidx];
					default: rd_val = UNMAPPED_READ;
				endcase
				merged = (rd_val & ~s_r.wmask) | (s_r.wdata & s_r.wmask);
				if (is_write_op(s_r.op)) begin
					case (s_r.rgn)
						reg_file_rgn: s_nxt.rf[s_r.addr[4:0]] = merged;
						sram_rgn: s_nxt.sram[sidx] = merged;
						std_io_rgn, ext_io_rgn: begin
							if (s_r.addr[7:0] == GP0_DATA_ADDR && s_r.addr[15:8] == 8'h00)
								s_nxt.gp[0] = merged;
							else if (s_r.addr[7:0] == GP1_DATA_ADDR && s_r.addr[15:8] == 8'h00)
								s_nxt.gp[1] = merged;
							else if (s_r.addr[7:0] == GP2_DATA_ADDR && s_r.addr[15:8] == 8'h00)
								s_nxt.gp[2] = merged;
							else if (s_r.addr[7:0] == FLAG_DATA_ADDR && s_r.addr[15:8] == 8'h00)
								flag_clr = s_r.wdata & s_r.wmask;
							else if (s_r.addr[7:0] == STORE_CTRL_ADDR && s_r.addr[15:8] == 8'h00)
								trig = s_r.wdata & s_r.wmask;
						end
						default: begin
						end
					endcase
				end
				if (s_r.op == data_space_load_ops || s_r.op == io_in_op) begin
					s_nxt.rf[s_r.rd] = rd_val;
				end
				if (s_r.rgn != none_rgn && (s_r.op == skip_if_io_bit_set_op || s_r.op == skip_if_io_bit_clear_op)) begin
					s_nxt.rsp.skip = rd_val[s_r.bit_idx] == (s_r.op == skip_if_io_bit_set_op);
				end
				// Pointer write-back follows the data, so it wins on a clash
				if (s_r.ptr_wb) begin
					s_nxt.rf[PTR_BASE_IDX + {2'b00, s_r.ptr_sel, 1'b0}] = s_r.ptr_nxt[7:0];
					s_nxt.rf[PTR_BASE_IDX + {2'b00, s_r.ptr_sel, 1'b1}] = s_r.ptr_nxt[15:8];
				end
				s_nxt.rsp.done  = 1'b1;
				s_nxt.rsp.rdata = rd_val;
				// A read trigger takes the longer stall if both bits are written
				if (trig[STORE_READ_BIT]) begin
					s_nxt.st        = ST_STALL;
					s_nxt.stall_cnt = STORE_READ_STALL;
				end else if (trig[STORE_WRITE_BIT]) begin
					s_nxt.st        = ST_STALL;
					s_nxt.stall_cnt = STORE_WRITE_STALL;
				end else begin
					s_nxt.st = ST_IDLE;
				end
			end
			ST_STALL: begin
				s_nxt.stall_cnt = s_r.stall_cnt - 3'h1;
				if (s_r.stall_cnt == 3'h1) begin
					s_nxt.st = ST_IDLE;
				end
			end
			default: s_nxt.st = ST_IDLE;
		endcase
		// Hardware set beats a software clear in the same cycle
		s_nxt.flags     = (s_r.flags & ~flag_clr) | FLAG_SET;
		s_nxt.rsp.ready = s_nxt.st == ST_IDLE;
		s_nxt.rsp.stall = s_nxt.st == ST_STALL;
	end

	always_ff @(posedge CLK_SYS) begin
		if (RESET) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign RSP   = s_r.rsp;
	assign IO    = s_r.io;
	assign FLAGS = s_r.flags;

	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (RESET);

	property p_reg_no_bus;
		take && region_of(fa_addr, SRAM_END) == reg_file_rgn |=> !IO.sel ##1 RSP.done;
	endproperty
	a_reg_no_bus: assert property (p_reg_no_bus) else $error("register-file access reached the I/O bus");

	property p_std_io;
		take && !is_bit_op(REQ.op) && region_of(fa_addr, SRAM_END) == std_io_rgn && !is_internal_io(fa_addr)
			|=> IO.sel && IO.addr < 8'h40;
	endproperty
	a_std_io: assert property (p_std_io) else $error("standard I/O access not placed on the bus");

	property p_ext_io;
		take && region_of(fa_addr, SRAM_END) == ext_io_rgn && !is_bit_op(REQ.op)
			|=> IO.sel && IO.addr >= 8'h40 && IO.addr < 8'hE0;
	endproperty
	a_ext_io: assert property (p_ext_io) else $error("extended I/O index out of range");

	property p_sram_two;
		take && region_of(fa_addr, SRAM_END) == sram_rgn |=> !RSP.done ##1 RSP.done;
	endproperty
	a_sram_two: assert property (p_sram_two) else $error("SRAM access not done in two cycles");

	property p_io_offset;
		take && REQ.op == io_out_op && !is_internal_io(fa_addr)
			|=> IO.sel && IO.we && IO.addr == {2'b00, $past(REQ.io_addr)};
	endproperty
	a_io_offset: assert property (p_io_offset) else $error("short I/O address offset wrong");

	property p_bit_limit;
		take && is_bit_op(REQ.op) && REQ.io_addr >= BIT_IO_LIMIT |=> !IO.sel ##1 (RSP.done && !RSP.skip);
	endproperty
	a_bit_limit: assert property (p_bit_limit) else $error("bit operation acted above I/O 0x1F");

	property p_bit_mask;
		IO.sel && IO.we && (s_r.op == set_io_bit_op || s_r.op == clear_io_bit_op)
			|-> $onehot(IO.wmask) && (IO.wdata & ~IO.wmask) == 8'h00;
	endproperty
	a_bit_mask: assert property (p_bit_mask) else $error("bit write touches more than one bit");

	property p_flag_set_wins;
		FLAG_SET[0] |=> FLAGS[0];
	endproperty
	a_flag_set_wins: assert property (p_flag_set_wins) else $error("flag set lost");

	property p_postinc;
		take && REQ.mode == mode_postinc && REQ.ptr == 2'h0 && REQ.rd < 5'h1A &&
			(REQ.op == data_space_load_ops || REQ.op == data_space_store_ops)
			|=> ##1 {s_r.rf[27], s_r.rf[26]} == $past(fa_ptr_nxt, 2);
	endproperty
	a_postinc: assert property (p_postinc) else $error("pointer not incremented");

	property p_read_stall;
		s_r.st == ST_ACCESS && s_nxt.stall_cnt == STORE_READ_STALL && s_nxt.st == ST_STALL
			|=> RSP.stall [*4] ##1 (!RSP.stall && RSP.ready);
	endproperty
	a_read_stall: assert property (p_read_stall) else $error("read stall is not four cycles");

	property p_write_stall;
		s_r.st == ST_ACCESS && s_nxt.stall_cnt == STORE_WRITE_STALL && s_nxt.st == ST_STALL
			|=> RSP.stall [*2] ##1 (!RSP.stall && RSP.ready);
	endproperty
	a_write_stall: assert property (p_write_stall) else $error("write stall is not two cycles");

	property p_none;
		take && region_of(fa_addr, SRAM_END) == none_rgn |=> !IO.sel ##1 RSP.rdata == UNMAPPED_READ;
	endproperty
	a_none: assert property (p_none) else $error("unmapped address selected a target");

	c_sram_load: cover property (take && REQ.op == data_space_load_ops && region_of(fa_addr, SRAM_END) == sram_rgn);
	c_bit_skip: cover property (RSP.done && RSP.skip);
	c_read_stall: cover property (RSP.stall [*4]);
	c_predec: cover property (take && REQ.mode == mode_predec);
endmodule

// ---- sim/io_periph_model.sv ----
`timescale 1ns/1ps
module io_periph_model import data_space_pkg::*; (
	input  logic        clk_sys,
	input  io_bus_s     io,
	output logic [7:0]  io_rdata
);
	logic [7:0] mem [256];
	logic [7:0] last_r;

	initial begin
		foreach (mem[i]) mem[i] = 8'h00;
		last_r = 8'h00;
	end

	// Only bits enabled in the mask may change
	always @(posedge clk_sys) begin
		if (io.sel && io.we)
			mem[io.addr] <= (mem[io.addr] & ~io.wmask) | (io.wdata & io.wmask);
		if (io.sel)
			last_r <= mem[io.addr];
	end

	// Unselected bus shows the inverse, so a late sample cannot match by luck
	assign io_rdata = io.sel ? mem[io.addr] : ~last_r;
endmodule

// ---- sim/data_space_decoder_test.sv ----
`timescale 1ns/1ps
module data_space_decoder_test import data_space_pkg::*;;
	localparam int          DEPTH_TB = 64;
	localparam logic [15:0] UNMAPPED = SRAM_BASE + 16'(DEPTH_TB);

	typedef struct packed {
		req_s       r;
		logic [7:0] e;
		logic [1:0] ck;
	} row_s;

	logic        clk_sys;
	logic        reset;
	req_s        req;
	rf_wr_s      reg_wr;
	logic [7:0]  io_rdata;
	logic [7:0]  flag_set;
	rsp_s        rsp;
	io_bus_s     io;
	logic [7:0]  flags;
	int          fail_count;
	int          total_checks;
	int          cycles;
	row_s        rows [26];
	logic [7:0]  d;
	logic        s;
	int          lat;
	int          st;

	data_space_decoder #(.DEPTH(DEPTH_TB)) i_dut (
		.CLK_SYS  (clk_sys),
		.RESET    (reset),
		.REQ      (req),
		.REG_WR   (reg_wr),
		.IO_RDATA (io_rdata),
		.FLAG_SET (flag_set),
		.RSP      (rsp),
		.IO       (io),
		.FLAGS    (flags)
	);

	io_periph_model i_periph (
		.clk_sys  (clk_sys),
		.io       (io),
		.io_rdata (io_rdata)
	);

	always #10 clk_sys = ~clk_sys;

	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Long runs mean a lost handshake
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 3000) begin
			fail_count++;
			results();
		end
	end

	function automatic req_s mk(op_e op, mode_e m, logic [1:0] p, logic [4:0] rd, logic [15:0] a,
		logic [5:0] dsp, logic [5:0] ioa, logic [2:0] b);
		return '{1'b1, op, m, p, rd, a, dsp, ioa, b};
	endfunction

	task automatic setreg(input logic [4:0] idx, input logic [7:0] val);
		reg_wr = '{1'b1, idx, val};
		@(negedge clk_sys);
		reg_wr.we = 1'b0;
		@(negedge clk_sys);
	endtask

	// Request is held for the take edge only, as the port allows
	task automatic do_req(input req_s r);
		int n;
		n = 0;
		while (rsp.ready !== 1'b1 && n < 50) begin
			@(negedge clk_sys);
			n++;
		end
		req = r;
		@(negedge clk_sys);
		req.valid = 1'b0;
		// The request cycle itself is the first of the two
		lat = 1;
		while (rsp.done !== 1'b1 && lat < 20) begin
			@(negedge clk_sys);
			lat++;
		end
		d = rsp.rdata;
		s = rsp.skip;
		st = 0;
		while (rsp.stall === 1'b1 && st < 20) begin
			@(negedge clk_sys);
			st++;
		end
	endtask

	initial begin
		clk_sys = 1'b0;
		reset = 1'b1;
		req = '0;
		reg_wr = '0;
		flag_set = 8'h00;
		fail_count = 0;
		total_checks = 0;
		cycles = 0;
		rows[0]  = '{mk(data_space_store_ops, mode_direct, 2'h0, 5'h01, 16'h0100, 6'h00, 6'h00, 3'h0), 8'h00, 2'h0};
		rows[1]  = '{mk(data_space_load_ops, mode_direct, 2'h0, 5'h02, 16'h0100, 6'h00, 6'h00, 3'h0), 8'hA5, 2'h1};
		rows[2]  = '{mk(data_space_store_ops, mode_direct, 2'h0, 5'h01, UNMAPPED - 16'h0001, 6'h00, 6'h00, 3'h0), 8'h00, 2'h0};
		rows[3]  = '{mk(data_space_load_ops, mode_disp, 2'h1, 5'h03, 16'h0000, 6'h3F, 6'h00, 3'h0), 8'hA5, 2'h1};
		rows[4]  = '{mk(data_space_load_ops, mode_postinc, 2'h0, 5'h04, 16'h0000, 6'h00, 6'h00, 3'h0), 8'hA5, 2'h1};
		rows[5]  = '{mk(data_space_load_ops, mode_direct, 2'h0, 5'h05, 16'h001A, 6'h00, 6'h00, 3'h0), 8'h01, 2'h1};
		rows[6]  = '{mk(data_space_load_ops, mode_predec, 2'h2, 5'h06, 16'h0000, 6'h00, 6'h00, 3'h0), 8'hA5, 2'h1};
		rows[7]  = '{mk(data_space_load_ops, mode_direct, 2'h0, 5'h07, 16'h001E, 6'h00, 6'h00, 3'h0), 8'h00, 2'h1};
		rows[8]  = '{mk(data_space_store_ops, mode_direct, 2'h0, 5'h01, 16'h0080, 6'h00, 6'h00, 3'h0), 8'h00, 2'h0};
		rows[9]  = '{mk(data_space_load_ops, mode_direct, 2'h0, 5'h08, 16'h0080, 6'h00, 6'h00, 3'h0), 8'hA5, 2'h1};
		rows[10] = '{mk(io_out_op, mode_direct, 2'h0, 5'h01, 16'h0000, 6'h00, 6'h10, 3'h0), 8'h00, 2'h0};
		rows[11] = '{mk(data_space_load_ops, mode_direct, 2'h0, 5'h09, 16'h0030, 6'h00, 6'h00, 3'h0), 8'hA5, 2'h1};
		rows[12] = '{mk(set_io_bit_op, mode_direct, 2'h0, 5'h00, 16'h0000, 6'h00, 6'h10, 3'h1), 8'h00, 2'h0};
		rows[13] = '{mk(data_space_load_ops, mode_direct, 2'h0, 5'h09, 16'h0030, 6'h00, 6'h00, 3'h0), 8'hA7, 2'h1};
		rows[14] = '{mk(data_space_store_ops, mode_direct, 2'h0, 5'h01, 16'h004A, 6'h00, 6'h00, 3'h0), 8'h00, 2'h0};
		rows[15] = '{mk(io_in_op, mode_direct, 2'h0, 5'h0A, 16'h0000, 6'h00, 6'h2A, 3'h0), 8'hA5, 2'h1};
		rows[16] = '{mk(data_space_load_ops, mode_direct, 2'h0, 5'h0A, 16'h0001, 6'h00, 6'h00, 3'h0), 8'hA5, 2'h1};
		rows[17] = '{mk(data_space_store_ops, mode_direct, 2'h0, 5'h01, UNMAPPED, 6'h00, 6'h00, 3'h0), 8'h00, 2'h0};
		rows[18] = '{mk(data_space_load_ops, mode_direct, 2'h0, 5'h0A, UNMAPPED, 6'h00, 6'h00, 3'h0), 8'h00, 2'h1};
		rows[19] = '{mk(set_io_bit_op, mode_direct, 2'h0, 5'h00, 16'h0000, 6'h00, 6'h1E, 3'h3), 8'h00, 2'h0};
		rows[20] = '{mk(skip_if_io_bit_set_op, mode_direct, 2'h0, 5'h00, 16'h0000, 6'h00, 6'h1E, 3'h3), 8'h01, 2'h2};
		rows[21] = '{mk(data_space_load_ops, mode_direct, 2'h0, 5'h0A, 16'h003E, 6'h00, 6'h00, 3'h0), 8'h08, 2'h1};
		rows[22] = '{mk(skip_if_io_bit_clear_op, mode_direct, 2'h0, 5'h00, 16'h0000, 6'h00, 6'h1E, 3'h3), 8'h00, 2'h2};
		rows[23] = '{mk(clear_io_bit_op, mode_direct, 2'h0, 5'h00, 16'h0000, 6'h00, 6'h1E, 3'h3), 8'h00, 2'h0};
		rows[24] = '{mk(data_space_load_ops, mode_direct, 2'h0, 5'h0A, 16'h003E, 6'h00, 6'h00, 3'h0), 8'h00, 2'h1};
		rows[25] = '{mk(set_io_bit_op, mode_direct, 2'h0, 5'h00, 16'h0000, 6'h00, 6'h20, 3'h0), 8'h00, 2'h3};
		repeat (2) @(negedge clk_sys);
		chk("ready in reset", {7'h00, rsp.ready}, 8'h00);
		reset = 1'b0;
		@(negedge clk_sys);
		chk("ready after reset", {7'h00, rsp.ready}, 8'h01);
		setreg(5'h01, 8'hA5);
		setreg(5'h1A, 8'h00);
		setreg(5'h1B, 8'h01);
		setreg(5'h1C, 8'h00);
		setreg(5'h1D, 8'h01);
		setreg(5'h1E, 8'h01);
		setreg(5'h1F, 8'h01);
		// Covers regions, pointer modes, bit ops and the unmapped boundary
		foreach (rows[i]) begin
			do_req(rows[i].r);
			chk($sformatf("latency row %0d", i), 8'(lat), 8'h02);
			if (rows[i].ck[0])
				chk($sformatf("rdata row %0d", i), d, rows[i].e);
			if (rows[i].ck[1])
				chk($sformatf("skip row %0d", i), {7'h00, s}, rows[i].e);
		end
		do_req(mk(data_space_load_ops, mode_indirect, 2'h1, 5'h0D, 16'h0000, 6'h00, 6'h00, 3'h0));
		chk("latency indirect", 8'(lat), 8'h02);
		chk("indirect load", d, 8'hA5);
		flag_set = 8'h03;
		@(negedge clk_sys);
		flag_set = 8'h00;
		@(negedge clk_sys);
		chk("flags set", flags, 8'h03);
		do_req(mk(set_io_bit_op, mode_direct, 2'h0, 5'h00, 16'h0000, 6'h00, 6'h15, 3'h0));
		@(negedge clk_sys);
		chk("flags bit op", flags, 8'h02);
		setreg(5'h0B, 8'h02);
		do_req(mk(data_space_store_ops, mode_direct, 2'h0, 5'h0B, 16'h0035, 6'h00, 6'h00, 3'h0));
		@(negedge clk_sys);
		chk("flags write one", flags, 8'h00);
		setreg(5'h0C, 8'h01);
		do_req(mk(data_space_store_ops, mode_direct, 2'h0, 5'h0C, 16'h003F, 6'h00, 6'h00, 3'h0));
		chk("read stall", 8'(st), 8'h04);
		setreg(5'h0C, 8'h02);
		do_req(mk(data_space_store_ops, mode_direct, 2'h0, 5'h0C, 16'h003F, 6'h00, 6'h00, 3'h0));
		chk("write stall", 8'(st), 8'h02);
		reset = 1'b1;
		repeat (2) @(negedge clk_sys);
		chk("ready second reset", {7'h00, rsp.ready}, 8'h00);
		reset = 1'b0;
		@(negedge clk_sys);
		do_req(mk(data_space_load_ops, mode_direct, 2'h0, 5'h02, 16'h0001, 6'h00, 6'h00, 3'h0));
		chk("register after reset", d, 8'h00);
		results();
	end
endmodule
